// *** hw/wdgt_top.sv ***
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// watchdog with axi4-lite register access
module wdgt_top
	import wdgt_pkg::*;
#(
	parameter int TICK_CYCLES = WDGT_TICK_CYCLES // shorten in simulation
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// axi4-lite slave
	input  wire logic [WDGT_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [WDGT_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// option straps, caught once after reset release
	input  wire logic                   activation_option,
	input  wire logic                   ext_stop_control_option,
	// pins and core hooks
	input  wire logic                   nmi_pin,
	input  wire logic                   rst_pin_in,
	output logic                        rst_pin_out,
	output logic                        rst_pin_oe,
	output logic                        stop_allow,
	output logic                        wdg_active
);
	// option straps and activation
	logic                   opt_valid_ff;  // straps captured
	logic                   hw_opt_ff;     // hardware activation selected
	logic                   ext_opt_ff;    // external stop control selected
	logic                   act_ff;        // watchdog active
	// counter, bit 6 is the soft_reset_bit
	logic [WDGT_CNT_W-1:0]  cnt_ff;
	logic [WDGT_CNT_W-1:0]  nxt_cnt;
	logic                   tick;          // decrement enable
	logic                   fire;          // reset condition
	logic                   pulse_busy;
	logic                   pulse_fired;
	logic                   stop_allow_ff;
	// write channel holding
	logic                   aw_hold_ff;
	logic [WDGT_ADDR_W-1:0] aw_addr_ff;
	logic                   w_hold_ff;
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;
	logic                   bvalid_ff;
	logic [1:0]             bresp_ff;
	logic                   wr_go;         // both halves present
	logic                   wr_count_en;   // count register byte 0 written
	// read channel
	logic                   rvalid_ff;
	logic [31:0]            rdata_ff;
	logic [1:0]             rresp_ff;
	logic [7:0]             count_view;    // software image of the counter
	logic [7:0]             status_view;

	// decrement enable
	wdgt_tick_div #(
		.TICK_CYCLES (TICK_CYCLES)
	) wdgt_tick_div_inst (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	// reset pin pulse
	wdgt_rst_pulse wdgt_rst_pulse_inst (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (fire),
		.busy    (pulse_busy),
		.fired   (pulse_fired)
	);

	// strap capture one edge after release; async reset only loads constants
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			opt_valid_ff <= 1'b0;
			hw_opt_ff    <= 1'b0;
			ext_opt_ff   <= 1'b0;
		end else if (!opt_valid_ff) begin
			opt_valid_ff <= 1'b1;
			hw_opt_ff    <= activation_option;
			ext_opt_ff   <= ext_stop_control_option;
		end
	end

	// activation bit: forced by the hardware option, sticky once set by software
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			act_ff <= 1'b0;
		end else if (!opt_valid_ff) begin
			act_ff <= activation_option;
		end else if (hw_opt_ff) begin
			act_ff <= 1'b1;
		end else if (wr_count_en && w_data_ff[WDGT_BIT_ACT]) begin
			act_ff <= 1'b1;
		end
	end

	// counter next value; a write wins over a decrement in the same cycle
	always_comb begin
		nxt_cnt = cnt_ff;
		if (wr_count_en) begin
			for (int i = 0; i < WDGT_CNT_W; i++) begin
				nxt_cnt[i] = w_data_ff[WDGT_CNT_W - i];
			end
		end else if (tick && !pulse_fired) begin
			// inactive it still wraps freely as a plain timer
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// counter register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= WDGT_CNT_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// soft_reset_bit low while active pulls the reset pin at once
	assign fire = opt_valid_ff && act_ff && !cnt_ff[WDGT_CNT_MSB];

	// open-drain reset pin, only ever pulled low
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe  = pulse_busy;

	// stop permission: inactive always, active only with option and nmi high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stop_allow_ff <= 1'b0;
		end else begin
			stop_allow_ff <= !act_ff || (ext_opt_ff && nmi_pin);
		end
	end

	assign stop_allow = stop_allow_ff;
	assign wdg_active = act_ff;

	// write address and data may arrive in any order; hold each until both
	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
	assign wr_go         = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign wr_count_en   = wr_go && (aw_addr_ff == WDGT_OFS_COUNT) && w_strb_ff[0];

	// write address holding
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_hold_ff <= 1'b0;
		end
	end

	// write data holding
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			w_hold_ff <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (wr_go) begin
			w_hold_ff <= 1'b0;
		end
	end

	// write response; status is read-only but answers okay, others slverr
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= WDGT_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			if (aw_addr_ff == WDGT_OFS_COUNT || aw_addr_ff == WDGT_OFS_STATUS) begin
				bresp_ff <= WDGT_RESP_OKAY;
			end else begin
				bresp_ff <= WDGT_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// register images for reads, counter shown bit-reversed
	always_comb begin
		count_view               = 8'h00;
		count_view[WDGT_BIT_ACT] = act_ff;
		for (int i = 0; i < WDGT_CNT_W; i++) begin
			count_view[WDGT_CNT_W - i] = cnt_ff[i];
		end
		status_view                 = 8'h00;
		status_view[WDGT_ST_ACT]    = act_ff;
		status_view[WDGT_ST_HWOPT]  = hw_opt_ff;
		status_view[WDGT_ST_EXTOPT] = ext_opt_ff;
		status_view[WDGT_ST_PULSE]  = pulse_busy;
		status_view[WDGT_ST_STOPOK] = stop_allow_ff;
		status_view[WDGT_ST_PIN]    = rst_pin_in;
		status_view[WDGT_ST_FIRED]  = pulse_fired;
	end

	// read channel, one outstanding read, answer one edge after the address
	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= WDGT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			if (s_axi_araddr == WDGT_OFS_COUNT) begin
				rdata_ff <= {24'h000000, count_view};
				rresp_ff <= WDGT_RESP_OKAY;
			end else if (s_axi_araddr == WDGT_OFS_STATUS) begin
				rdata_ff <= {24'h000000, status_view};
				rresp_ff <= WDGT_RESP_OKAY;
			end else begin
				rdata_ff <= 32'h00000000;
				rresp_ff <= WDGT_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_load_long;
		wr_count_en && w_data_ff[7:0] == 8'hfe;
	endsequence

	sequence s_load_short;
		wr_count_en && w_data_ff[7:0] == 8'h02;
	endsequence

	a_load_longest: assert property (
		s_load_long |=> cnt_ff == 7'h7f)
		else $error("reload fe did not give the longest count");
	a_load_shortest: assert property (
		s_load_short ##1 !wr_count_en[*1] |-> cnt_ff == 7'h40)
		else $error("reload 02 did not give the shortest count");
	a_reverse_order: assert property (
		wr_count_en |=> cnt_ff[WDGT_CNT_MSB] == $past(w_data_ff[WDGT_BIT_SOFTRST]) && cnt_ff[0] == $past(w_data_ff[7]))
		else $error("counter bit order not reversed");
	a_sr_clear_rst: assert property (
		act_ff && opt_valid_ff && !cnt_ff[WDGT_CNT_MSB] && !pulse_fired |=> rst_pin_oe)
		else $error("cleared soft reset bit did not pull the reset pin");
	a_decrement_step: assert property (
		tick && !wr_count_en && !pulse_fired |=> cnt_ff == $past(cnt_ff) - 7'h01)
		else $error("counter missed a decrement");
	a_timer_quiet: assert property (
		!act_ff |-> !fire ##1 !rst_pin_oe || $past(pulse_busy))
		else $error("inactive watchdog caused a reset");
	a_hw_forced: assert property (
		opt_valid_ff && hw_opt_ff |-> act_ff)
		else $error("hardware option did not keep the watchdog active");
	a_act_sticky: assert property (
		act_ff |=> act_ff)
		else $error("watchdog deactivated");
	a_stop_nmi_high: assert property (
		act_ff && ext_opt_ff && nmi_pin |=> stop_allow)
		else $error("stop refused with nmi high");
	a_stop_nmi_low: assert property (
		act_ff && !nmi_pin |=> !stop_allow)
		else $error("stop allowed while protection required");
	// bus answers: a held write pair is answered, a taken address is answered next cycle
	a_write_answer: assert property (
		wr_go |=> s_axi_bvalid)
		else $error("write pair held but no response raised");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read address taken but no data raised");
	a_wr_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted while a response is pending");
endmodule : wdgt_top

// *** hw/wdgt_pkg.sv ***
// Behaviour
// - reload FEh longest, 02h shortest timeout
// - clearing soft_reset_bit while active resets at once
// - external stop control: nmi high allows stop
// - external stop control: nmi low blocks stop
// - inactive software watchdog still counts as timer
// - counter bits read in reversed order
// - decrement once every 3072 internal clocks
// - hardware option forces activation, ignores activation bit writes
// - software option: activation by write, sticky
// - reset pin driven low about 500ns
package wdgt_pkg;
	// register map, byte addresses on the bus
	localparam int               WDGT_ADDR_W      = 8;
	localparam logic [7:0]       WDGT_OFS_COUNT   = 8'h00;     // watchdog_count_reg
	localparam logic [7:0]       WDGT_OFS_STATUS  = 8'h04;     // read-only status
	// watchdog_count_reg layout
	localparam int               WDGT_BIT_ACT     = 0;         // activation bit
	localparam int               WDGT_BIT_SOFTRST = 1;         // soft_reset_bit
	localparam int               WDGT_CNT_W       = 7;         // soft_reset_bit plus six count bits
	localparam int               WDGT_CNT_MSB     = 6;         // counter bit that holds soft_reset_bit
	localparam logic [6:0]       WDGT_CNT_RST     = 7'h7f;     // same as a reload of 8'hfe
	// status register layout
	localparam int               WDGT_ST_ACT      = 0;
	localparam int               WDGT_ST_HWOPT    = 1;
	localparam int               WDGT_ST_EXTOPT   = 2;
	localparam int               WDGT_ST_PULSE    = 3;
	localparam int               WDGT_ST_STOPOK   = 4;
	localparam int               WDGT_ST_PIN      = 5;
	localparam int               WDGT_ST_FIRED    = 6;
	// timing: internal clock 8 MHz, one decrement per 3072 internal clocks
	localparam int               WDGT_FINT_KHZ    = 8000;
	localparam int               WDGT_TICK_FINT   = 3072;
	localparam int               WDGT_CLK_NS      = 8;
	localparam int               WDGT_TICK_NS     = WDGT_TICK_FINT * 1000 / (WDGT_FINT_KHZ / 1000);
	localparam int               WDGT_TICK_CYCLES = WDGT_TICK_NS / WDGT_CLK_NS;
	localparam int               WDGT_PULSE_NS    = 500;
	localparam int               WDGT_PULSE_CYCLES = (WDGT_PULSE_NS + WDGT_CLK_NS - 1) / WDGT_CLK_NS;
	// bus answers
	localparam logic [1:0]       WDGT_RESP_OKAY   = 2'h0;
	localparam logic [1:0]       WDGT_RESP_SLVERR = 2'h2;
	// reset pulse sequencing
	typedef enum logic [1:0] {
		WDGT_P_IDLE,
		WDGT_P_LOW,
		WDGT_P_DONE
	} wdgt_pulse_st_type;
endpackage : wdgt_pkg

// *** hw/wdgt_tick_div.sv ***
`timescale 1ns/1ns
// one-cycle enable every TICK_CYCLES clocks
module wdgt_tick_div
	import wdgt_pkg::*;
#(
	parameter int TICK_CYCLES = WDGT_TICK_CYCLES
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	output logic      tick
);
	localparam int                 DW   = $clog2(TICK_CYCLES + 1);
	localparam logic [DW-1:0]      LAST = DW'(TICK_CYCLES - 1);

	logic [DW-1:0] div_ff;    // free-running prescale count
	logic          tick_ff;   // registered enable
	logic [DW:0]   gap_ff;    // cycles since last tick, checking only
	logic          seen_ff;   // first tick observed

	// prescaler, free running so software writes do not jitter the period
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (div_ff == LAST) begin
			div_ff  <= '0;
			tick_ff <= 1'b1;
		end else begin
			div_ff  <= div_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;

	// spacing observer for the assertion
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_ff  <= '0;
			seen_ff <= 1'b0;
		end else if (tick_ff) begin
			gap_ff  <= (DW+1)'(1);
			seen_ff <= 1'b1;
		end else begin
			gap_ff  <= gap_ff + 1'b1;
		end
	end

	a_tick_period: assert property (@(posedge clk) disable iff (sys_rst)
		tick_ff && seen_ff |-> gap_ff == (DW+1)'(TICK_CYCLES))
		else $error("tick spacing differs from the decrement period");
endmodule : wdgt_tick_div

// *** hw/wdgt_rst_pulse.sv ***
`timescale 1ns/1ns
// single low pulse on the reset pin, no retrigger until system reset
module wdgt_rst_pulse
	import wdgt_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic start,
	output logic      busy,
	output logic      fired
);
	localparam int         PW   = $clog2(WDGT_PULSE_CYCLES + 1);
	localparam logic [PW-1:0] LAST = PW'(WDGT_PULSE_CYCLES - 1);

	wdgt_pulse_st_type st_ff;     // pulse state
	logic [PW-1:0]     len_ff;    // cycles spent low
	logic [PW:0]       obs_ff;    // checking only: measured width

	// pulse state machine; done is final, the device is expected to be reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff  <= WDGT_P_IDLE;
			len_ff <= '0;
		end else begin
			unique case (st_ff)
				WDGT_P_IDLE: begin
					if (start) begin
						st_ff <= WDGT_P_LOW;
					end
				end
				WDGT_P_LOW: begin
					len_ff <= len_ff + 1'b1;
					if (len_ff == LAST) begin
						st_ff <= WDGT_P_DONE;
					end
				end
				WDGT_P_DONE: begin
					st_ff <= WDGT_P_DONE;
				end
				default: begin
					st_ff <= WDGT_P_IDLE;
				end
			endcase
		end
	end

	assign busy  = (st_ff == WDGT_P_LOW);
	assign fired = (st_ff != WDGT_P_IDLE);

	// width observer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			obs_ff <= '0;
		end else if (busy) begin
			obs_ff <= obs_ff + 1'b1;
		end
	end

	a_pulse_width: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(busy) |-> obs_ff == (PW+1)'(WDGT_PULSE_CYCLES))
		else $error("reset pulse width wrong");
	a_pulse_start: assert property (@(posedge clk) disable iff (sys_rst)
		start && !fired |=> busy)
		else $error("reset pulse did not start at once");
endmodule : wdgt_rst_pulse

// *** verif/wdgt_top_tb.sv ***
`timescale 1ns/1ns
// bench for the watchdog: drives the axi4-lite port, the straps and the nmi pin itself
module wdgt_top_tb
	import wdgt_pkg::*;
;
	localparam int TICK = 8;                 // short prescaler so a full timeout fits the run
	logic                   clk;             // 125 MHz system clock
	logic                   sys_rst;         // async reset, active high
	logic [WDGT_ADDR_W-1:0] s_axi_awaddr;
	logic                   s_axi_awvalid;
	logic                   s_axi_awready;
	logic [31:0]            s_axi_wdata;
	logic [3:0]             s_axi_wstrb;
	logic                   s_axi_wvalid;
	logic                   s_axi_wready;
	logic [1:0]             s_axi_bresp;
	logic                   s_axi_bvalid;
	logic                   s_axi_bready;
	logic [WDGT_ADDR_W-1:0] s_axi_araddr;
	logic                   s_axi_arvalid;
	logic                   s_axi_arready;
	logic [31:0]            s_axi_rdata;
	logic [1:0]             s_axi_rresp;
	logic                   s_axi_rvalid;
	logic                   s_axi_rready;
	logic                   activation_option;        // strap, 1 = hardware activation
	logic                   ext_stop_control_option;  // strap, stop gated by nmi
	logic                   nmi_pin;
	logic                   rst_pin_in;
	logic                   rst_pin_out;
	logic                   rst_pin_oe;
	logic                   stop_allow;
	logic                   wdg_active;
	int                     fails;           // mismatch count
	int                     checks_done;     // comparison count
	logic [31:0]            d;               // last read data
	logic [1:0]             r;               // last response code
	int                     k;

	// device under test, prescaler shortened
	wdgt_top #(.TICK_CYCLES(TICK)) wdgt_top_inst (
		.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.activation_option(activation_option), .ext_stop_control_option(ext_stop_control_option),
		.nmi_pin(nmi_pin), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
		.rst_pin_oe(rst_pin_oe), .stop_allow(stop_allow), .wdg_active(wdg_active)
	);

	// free-running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// one comparison, mismatch reported at once
	task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check_eq

	// verdict and end of run
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// re-reset with new straps; straps are caught only after release
	task automatic do_reset(input logic hw, input logic ext);
		@(posedge clk);
		sys_rst                 <= 1'b1;
		activation_option       <= hw;
		ext_stop_control_option <= ext;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : do_reset

	// axi4-lite write; readiness sampled mid-cycle so the handshake edge is known without a race
	task automatic axi_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
		logic aw;
		logic w;
		logic ta;
		logic tw;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		aw = 1'b0;
		w  = 1'b0;
		while (!(aw && w)) begin
			@(negedge clk);
			ta = !aw && s_axi_awready;
			tw = !w && s_axi_wready;
			@(posedge clk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				aw = 1'b1;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				w = 1'b1;
			end
		end
		// no cycle count assumed; only the hang guard ends this wait
		@(negedge clk);
		while (s_axi_bvalid !== 1'b1) @(negedge clk);
		resp = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : axi_write

	// axi4-lite read, rready held until rvalid is seen
	task automatic axi_read(input logic [7:0] a, output logic [31:0] data, output logic [1:0] resp);
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		@(negedge clk);
		while (s_axi_arready !== 1'b1) @(negedge clk);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		// rvalid is launched by the edge above, so look only once it has settled
		@(negedge clk);
		while (s_axi_rvalid !== 1'b1) @(negedge clk);
		data = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : axi_read

	// pulse must start within [lo, hi) cycles, then hold the pin low for the full pulse length
	task automatic expect_pulse(input int lo, input int hi);
		int n;
		int w;
		@(negedge clk);
		for (n = 0; n < hi && rst_pin_oe !== 1'b1; n++) @(negedge clk);
		check_eq(32'(n >= lo && n < hi), 32'h1);
		check_eq(32'(rst_pin_out), 32'h0);
		for (w = 0; w < 200 && rst_pin_oe === 1'b1; w++) @(negedge clk);
		check_eq(32'(w), 32'(WDGT_PULSE_CYCLES));
	endtask : expect_pulse

	// hang guard, far beyond the fewer than a thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		final_report();
	end

	// main sequence
	initial begin
		fails = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		activation_option = 1'b0;
		ext_stop_control_option = 1'b0;
		nmi_pin = 1'b1;
		rst_pin_in = 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		// software option: idle after reset, counter usable as a plain timer
		axi_read(WDGT_OFS_COUNT, d, r);
		check_eq(d, 32'h000000fe);
		check_eq(32'(wdg_active), 32'h0);
		axi_read(WDGT_OFS_STATUS, d, r);
		check_eq(d, 32'h00000030);
		axi_write(WDGT_OFS_COUNT, 8'h02, r);
		for (k = 0; k < 8; k++) begin
			axi_read(WDGT_OFS_COUNT, d, r);
			if (d !== 32'h00000002) break;
		end
		check_eq(d, 32'h000000fc);
		check_eq(32'(wdg_active), 32'h0);
		// activation is sticky once written
		axi_write(WDGT_OFS_COUNT, 8'hff, r);
		check_eq(32'(wdg_active), 32'h1);
		axi_write(WDGT_OFS_COUNT, 8'hfe, r);
		check_eq(32'(wdg_active), 32'h1);
		// clearing the soft reset bit while active fires at once
		axi_write(WDGT_OFS_COUNT, 8'hfd, r);
		expect_pulse(0, 4);
		axi_read(WDGT_OFS_STATUS, d, r);
		check_eq(32'(d[WDGT_ST_FIRED]), 32'h1);
		// hardware option with external stop control
		do_reset(1'b1, 1'b1);
		check_eq(32'(wdg_active), 32'h1);
		@(posedge clk);
		nmi_pin <= 1'b1;
		repeat (2) @(negedge clk);
		check_eq(32'(stop_allow), 32'h1);
		@(posedge clk);
		nmi_pin <= 1'b0;
		repeat (2) @(negedge clk);
		check_eq(32'(stop_allow), 32'h0);
		// longest reload: no pulse before 62 ticks, pulse within 64 ticks plus 16 cycles
		axi_write(WDGT_OFS_COUNT, 8'hfe, r);
		expect_pulse(62 * TICK, 64 * TICK + 16);
		check_eq(32'(wdg_active), 32'h1);
		axi_read(WDGT_OFS_COUNT, d, r);
		check_eq(32'(d[WDGT_BIT_ACT]), 32'h1);
		// hardware option alone; shortest reload ends after one tick
		do_reset(1'b1, 1'b0);
		@(posedge clk);
		nmi_pin <= 1'b1;
		repeat (2) @(negedge clk);
		check_eq(32'(stop_allow), 32'h0);
		axi_write(WDGT_OFS_COUNT, 8'h02, r);
		expect_pulse(0, TICK + 8);
		// unmapped address answers with an error and no data
		axi_read(8'h08, d, r);
		check_eq(d, 32'h00000000);
		check_eq(32'(r), 32'(WDGT_RESP_SLVERR));
		axi_write(8'h08, 8'h55, r);
		check_eq(32'(r), 32'(WDGT_RESP_SLVERR));
		axi_write(WDGT_OFS_STATUS, 8'h00, r);
		check_eq(32'(r), 32'(WDGT_RESP_OKAY));
		final_report();
	end
endmodule : wdgt_top_tb
